// ---- rtl/irq_arbiter.sv ----
`timescale 1ns/10ps
`default_nettype none
`include "irq_unit_defines.svh"

module irq_arbiter #(
  parameter int NSRC = `NUM_SRC
) (
  // Requests and their levels, three bits per source
  input wire logic [NSRC-1:0] pend,
  input wire logic [3*NSRC-1:0] lvl,
  // Winner
  output logic valid,
  output logic [3:0] src,
  output logic [2:0] level
);

  // Scan from highest index downward; ">=" lets a lower index take a tie
  always_comb begin
    valid = 1'b0;
    src = 4'h0;
    level = 3'h0;
    for (int i = NSRC - 1; i >= 0; i--) begin
      if (pend[i] && (!valid || lvl[3*i +: 3] >= level)) begin
        valid = 1'b1;
        src = 4'(i);
        level = lvl[3*i +: 3];
      end
    end
  end

endmodule : irq_arbiter
`default_nettype wire

// ---- rtl/irq_unit_defines.svh ----
`ifndef IRQ_UNIT_DEFINES_SVH
`define IRQ_UNIT_DEFINES_SVH

// Sizes
`define NUM_SRC 13
`define NUM_EXT 6
`define NUM_LVL 5
`define FLAG_W 16
`define ADDR_W 6

// Register byte addresses
`define OFS_IE 6'h00
`define OFS_EIE 6'h04
`define OFS_PLOW 6'h08
`define OFS_PMID 6'h0c
`define OFS_EPLOW 6'h10
`define OFS_EPMID 6'h14
`define OFS_FLAG_CLR 6'h18
`define OFS_FLAG_SET 6'h1c
`define OFS_CTRL 6'h20
`define OFS_STATUS 6'h24

// Field positions
`define IE_GLOBAL_BIT 7
`define EIE_WDOG_BIT 4
`define CTL_PF_EN_BIT 0
`define CTL_EXT0_LVL_BIT 1
`define CTL_EXT1_LVL_BIT 2
`define CTL_W 3

// Flag register layout
`define FLG_EXT0 0
`define FLG_TF0 1
`define FLG_EXT1 2
`define FLG_TF1 3
`define FLG_RI0 4
`define FLG_TI0 5
`define FLG_TF2 6
`define FLG_TIMER2_EXTERNAL_FLAG 7
`define FLG_RI1 8
`define FLG_TI1 9
`define FLG_EXT2 10
`define FLG_WDOG 14
`define FLG_PF 15

// Natural order of sources
`define SRC_PF 4'h0
`define SRC_EXT0 4'h1
`define SRC_TF0 4'h2
`define SRC_EXT1 4'h3
`define SRC_TF1 4'h4
`define SRC_SER0 4'h5
`define SRC_TMR2 4'h6
`define SRC_SER1 4'h7
`define SRC_EXT2 4'h8
`define SRC_WDOG 4'hc
`define IE_SRC_COUNT 7

// Vector addresses
`define VEC_PF 8'h33
`define VEC_EXT0 8'h03
`define VEC_TF0 8'h0b
`define VEC_EXT1 8'h13
`define VEC_TF1 8'h1b
`define VEC_SER0 8'h23
`define VEC_TMR2 8'h2b
`define VEC_SER1 8'h3b
`define VEC_EXT2 8'h43
`define VEC_EXT3 8'h4b
`define VEC_EXT4 8'h53
`define VEC_EXT5 8'h5b
`define VEC_WDOG 8'h63

// Levels and reset values
`define LVL_PF 3'h4
`define RST_BYTE 8'h00

`endif

// ---- rtl/irq_unit_pkg.sv ----
`include "irq_unit_defines.svh"

package irq_unit_pkg;

  typedef enum logic {BUS_IDLE, BUS_ACK} bus_state_type;

  typedef struct packed {
    bus_state_type bus;
    logic waitrequest;
    logic [31:0] rdata;
    logic [7:0] ie;
    logic [7:0] ext_irq_enable_reg;
    logic [7:0] plow;
    logic [7:0] pmid;
    logic [7:0] eplow;
    logic [7:0] epmid;
    logic [`CTL_W-1:0] ctl;
    logic [`FLAG_W-1:0] flags;
    logic [`NUM_EXT-1:0] ext_s1;
    logic [`NUM_EXT-1:0] ext_s2;
    logic [`NUM_EXT-1:0] ext_prev;
    logic pf_s1;
    logic pf_s2;
    logic pf_prev;
    logic [`NUM_LVL-1:0] in_service;
    logic req;
    logic [7:0] vector;
    logic [2:0] level;
    logic [3:0] src;
  } state_type;

endpackage : irq_unit_pkg

// ---- rtl/vectored_irq_unit.sv ----
// How it works
// - Thirteen sources, each with its own vector address.
// - Non-power-fail sources need their own enable and the global enable.
// - Global enable low blocks all gated sources.
// - Power-fail is gated only by its own enable, not global enable.
// - Five levels, 4 highest, level 4 belongs to power-fail only.
// - Other sources take level 3..0 from low and mid priority registers.
// - Enabled pending power-fail beats every other source.
// - Ties at a level go to the lowest natural order, power-fail first.
// - External 0 vector 03h, external 1 vector 13h.
// - Timer 0, 1, 2 vectors 0Bh, 1Bh, 2Bh.
// - External 2..5 vectors 43h, 4Bh, 53h, 5Bh.
// - Flags set on their event whether enabled or not.
// - Timer 0 and 1 flags clear when the core vectors to them.
// - External 0/1 clear on vectoring in edge mode, follow pin in level mode.
// - Timer 2 requests on overflow or external flag, one vector.
// - Watchdog enable and priority bit 4 of extended enable and priority registers.
//
// Local design decisions: the Avalon-MM interface to the registers and the register offsets.
`timescale 1ns/10ps
`default_nettype none
`include "irq_unit_defines.svh"

module vectored_irq_unit
  import irq_unit_pkg::*;
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // Avalon-MM slave
  input wire logic [`ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // External interrupt pins, active low, asynchronous
  input wire logic [`NUM_EXT-1:0] ext_irq_pin_n,
  // Power-fail warning from the supply monitor, asynchronous
  input wire logic powerfail_warn,
  // Event pulses from on-chip peripherals
  input wire logic timer0_ovf_pulse,
  input wire logic timer1_ovf_pulse,
  input wire logic timer2_ovf_pulse,
  input wire logic timer2_ext_pulse,
  input wire logic serial0_rx_pulse,
  input wire logic serial0_tx_pulse,
  input wire logic serial1_rx_pulse,
  input wire logic serial1_tx_pulse,
  input wire logic wdog_timeout_pulse,
  // Processor core
  input wire logic vector_ack,
  input wire logic service_return,
  output logic irq_req,
  output logic [7:0] irq_vector,
  output logic [2:0] irq_level
);

  state_type s_r;
  state_type s_nxt;

  logic [`NUM_SRC-1:0] pend;
  logic [3*`NUM_SRC-1:0] lvl;
  logic arb_valid;
  logic [3:0] arb_src;
  logic [2:0] arb_level;

  //////////////////////////////////////////////////////////////////////////////
  // Helpers

  function automatic logic [7:0] vector_of(input logic [3:0] src);
    case (src)
      `SRC_PF: vector_of = `VEC_PF;
      `SRC_EXT0: vector_of = `VEC_EXT0;
      `SRC_TF0: vector_of = `VEC_TF0;
      `SRC_EXT1: vector_of = `VEC_EXT1;
      `SRC_TF1: vector_of = `VEC_TF1;
      `SRC_SER0: vector_of = `VEC_SER0;
      `SRC_TMR2: vector_of = `VEC_TMR2;
      `SRC_SER1: vector_of = `VEC_SER1;
      4'h8: vector_of = `VEC_EXT2;
      4'h9: vector_of = `VEC_EXT3;
      4'ha: vector_of = `VEC_EXT4;
      4'hb: vector_of = `VEC_EXT5;
      `SRC_WDOG: vector_of = `VEC_WDOG;
      default: vector_of = `VEC_PF;
    endcase
  endfunction : vector_of

  // Running level plus one, zero when no routine is in service
  function automatic logic [2:0] running_of(input logic [`NUM_LVL-1:0] isr);
    running_of = 3'h0;
    for (int i = 0; i < `NUM_LVL; i++) begin
      if (isr[i]) begin
        running_of = 3'(i + 1);
      end
    end
  endfunction : running_of

  function automatic logic [31:0] byte_mask(input logic [3:0] be);
    byte_mask = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
  endfunction : byte_mask

  //////////////////////////////////////////////////////////////////////////////
  // Pending and level vectors

  always_comb begin
    pend = '0;
    lvl = '0;
    pend[`SRC_PF] = s_r.flags[`FLG_PF] && s_r.ctl[`CTL_PF_EN_BIT];
    lvl[3*`SRC_PF +: 3] = `LVL_PF;
    for (int i = 1; i <= `IE_SRC_COUNT; i++) begin
      lvl[3*i +: 3] = {1'b0, s_r.pmid[i-1], s_r.plow[i-1]};
    end
    for (int i = 0; i <= `EIE_WDOG_BIT; i++) begin
      lvl[3*(i+`IE_SRC_COUNT+1) +: 3] = {1'b0, s_r.epmid[i], s_r.eplow[i]};
    end
    pend[`SRC_EXT0] = s_r.flags[`FLG_EXT0] && s_r.ie[0];
    pend[`SRC_TF0] = s_r.flags[`FLG_TF0] && s_r.ie[1];
    pend[`SRC_EXT1] = s_r.flags[`FLG_EXT1] && s_r.ie[2];
    pend[`SRC_TF1] = s_r.flags[`FLG_TF1] && s_r.ie[3];
    pend[`SRC_SER0] = (s_r.flags[`FLG_RI0] || s_r.flags[`FLG_TI0]) && s_r.ie[4];
    pend[`SRC_TMR2] = (s_r.flags[`FLG_TF2] || s_r.flags[`FLG_TIMER2_EXTERNAL_FLAG]) && s_r.ie[5];
    pend[`SRC_SER1] = (s_r.flags[`FLG_RI1] || s_r.flags[`FLG_TI1]) && s_r.ie[6];
    for (int i = 0; i < `EIE_WDOG_BIT; i++) begin
      pend[`SRC_EXT2 + i] = s_r.flags[`FLG_EXT2 + i] && s_r.ext_irq_enable_reg[i];
    end
    pend[`SRC_WDOG] = s_r.flags[`FLG_WDOG] && s_r.ext_irq_enable_reg[`EIE_WDOG_BIT];
    // Global enable masks everything but power-fail
    if (!s_r.ie[`IE_GLOBAL_BIT]) begin
      pend[`NUM_SRC-1:1] = '0;
    end
  end

  irq_arbiter #(
    .NSRC(`NUM_SRC)
  ) u_arbiter (
    .pend(pend),
    .lvl(lvl),
    .valid(arb_valid),
    .src(arb_src),
    .level(arb_level)
  );

  //////////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb begin
    logic [`FLAG_W-1:0] set_v;
    logic [`FLAG_W-1:0] clr_v;
    logic [`NUM_EXT-1:0] fall_v;
    logic [31:0] mask_v;
    logic [31:0] rd_v;
    logic pf_rise_v;
    logic do_wr_v;
    set_v = '0;
    clr_v = '0;
    fall_v = '0;
    mask_v = '0;
    rd_v = '0;
    pf_rise_v = 1'b0;
    do_wr_v = 1'b0;
    s_nxt = s_r;

    // Two-stage synchronisers; edges are taken after the second stage only
    s_nxt.ext_s1 = ext_irq_pin_n;
    s_nxt.ext_s2 = s_r.ext_s1;
    s_nxt.ext_prev = s_r.ext_s2;
    s_nxt.pf_s1 = powerfail_warn;
    s_nxt.pf_s2 = s_r.pf_s1;
    s_nxt.pf_prev = s_r.pf_s2;
    fall_v = s_r.ext_prev & ~s_r.ext_s2;
    pf_rise_v = s_r.pf_s2 && !s_r.pf_prev;

    // Hardware events set flags regardless of enables
    set_v[`FLG_EXT0] = fall_v[0];
    set_v[`FLG_TF0] = timer0_ovf_pulse;
    set_v[`FLG_EXT1] = fall_v[1];
    set_v[`FLG_TF1] = timer1_ovf_pulse;
    set_v[`FLG_RI0] = serial0_rx_pulse;
    set_v[`FLG_TI0] = serial0_tx_pulse;
    set_v[`FLG_TF2] = timer2_ovf_pulse;
    set_v[`FLG_TIMER2_EXTERNAL_FLAG] = timer2_ext_pulse;
    set_v[`FLG_RI1] = serial1_rx_pulse;
    set_v[`FLG_TI1] = serial1_tx_pulse;
    set_v[`FLG_EXT2 +: 4] = fall_v[5:2];
    set_v[`FLG_WDOG] = wdog_timeout_pulse;
    set_v[`FLG_PF] = pf_rise_v;

    // Bus: one wait cycle, then the answer; writes land on the answer edge
    case (s_r.bus)
      BUS_IDLE: begin
        if (avs_read || avs_write) begin
          case (avs_address)
            `OFS_IE: rd_v = {24'h000000, s_r.ie};
            `OFS_EIE: rd_v = {24'h000000, s_r.ext_irq_enable_reg};
            `OFS_PLOW: rd_v = {24'h000000, s_r.plow};
            `OFS_PMID: rd_v = {24'h000000, s_r.pmid};
            `OFS_EPLOW: rd_v = {24'h000000, s_r.eplow};
            `OFS_EPMID: rd_v = {24'h000000, s_r.epmid};
            `OFS_FLAG_CLR: rd_v = {16'h0000, s_r.flags};
            `OFS_FLAG_SET: rd_v = {16'h0000, s_r.flags};
            `OFS_CTRL: rd_v = {29'h00000000, s_r.ctl};
            `OFS_STATUS: rd_v = {11'h000, s_r.in_service, s_r.req, s_r.level,
                                 s_r.src, s_r.vector};
            default: rd_v = '0;
          endcase
          s_nxt.rdata = rd_v;
          s_nxt.waitrequest = 1'b0;
          s_nxt.bus = BUS_ACK;
        end
      end
      BUS_ACK: begin
        do_wr_v = avs_write;
        s_nxt.waitrequest = 1'b1;
        s_nxt.bus = BUS_IDLE;
      end
      default: begin
        s_nxt.waitrequest = 1'b1;
        s_nxt.bus = BUS_IDLE;
      end
    endcase

    if (do_wr_v) begin
      mask_v = byte_mask(avs_byteenable) & avs_writedata;
      case (avs_address)
        `OFS_IE: s_nxt.ie = avs_byteenable[0] ? avs_writedata[7:0] : s_r.ie;
        `OFS_EIE: s_nxt.ext_irq_enable_reg = avs_byteenable[0] ? avs_writedata[7:0] : s_r.ext_irq_enable_reg;
        `OFS_PLOW: s_nxt.plow = avs_byteenable[0] ? avs_writedata[7:0] : s_r.plow;
        `OFS_PMID: s_nxt.pmid = avs_byteenable[0] ? avs_writedata[7:0] : s_r.pmid;
        `OFS_EPLOW: s_nxt.eplow = avs_byteenable[0] ? avs_writedata[7:0] : s_r.eplow;
        `OFS_EPMID: s_nxt.epmid = avs_byteenable[0] ? avs_writedata[7:0] : s_r.epmid;
        `OFS_FLAG_CLR: clr_v = clr_v | mask_v[`FLAG_W-1:0];
        `OFS_FLAG_SET: set_v = set_v | mask_v[`FLAG_W-1:0];
        `OFS_CTRL: s_nxt.ctl = avs_byteenable[0] ? avs_writedata[`CTL_W-1:0] : s_r.ctl;
        default: ;
      endcase
    end

    // Core takes the offered vector: push its level, auto-clear its flag if timer 0/1 or edge-mode external 0/1
    if (vector_ack && s_r.req) begin
      s_nxt.in_service[s_r.level] = 1'b1;
      case (s_r.src)
        `SRC_TF0: clr_v[`FLG_TF0] = 1'b1;
        `SRC_TF1: clr_v[`FLG_TF1] = 1'b1;
        `SRC_EXT0: clr_v[`FLG_EXT0] = !s_r.ctl[`CTL_EXT0_LVL_BIT];
        `SRC_EXT1: clr_v[`FLG_EXT1] = !s_r.ctl[`CTL_EXT1_LVL_BIT];
        default: ;
      endcase
    end else if (service_return) begin
      for (int i = 0; i < `NUM_LVL; i++) begin
        if (3'(i + 1) == running_of(s_r.in_service)) begin
          s_nxt.in_service[i] = 1'b0;
        end
      end
    end

    // A new event wins over a clear in the same cycle
    s_nxt.flags = (s_r.flags & ~clr_v) | set_v;
    // Level mode: the flag simply mirrors the pin
    if (s_r.ctl[`CTL_EXT0_LVL_BIT]) begin
      s_nxt.flags[`FLG_EXT0] = !s_r.ext_s2[0];
    end
    if (s_r.ctl[`CTL_EXT1_LVL_BIT]) begin
      s_nxt.flags[`FLG_EXT1] = !s_r.ext_s2[1];
    end

    // Request drops for the acknowledge cycle so one vector is never taken twice
    s_nxt.req = arb_valid && !vector_ack
                && ((arb_level + 3'h1) > running_of(s_r.in_service));
    s_nxt.src = arb_src;
    s_nxt.level = arb_level;
    s_nxt.vector = vector_of(arb_src);
  end

  //////////////////////////////////////////////////////////////////////////////
  // State register

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      s_r <= '0;
      s_r.waitrequest <= 1'b1;
      s_r.ext_s1 <= '1;
      s_r.ext_s2 <= '1;
      s_r.ext_prev <= '1;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign avs_readdata = s_r.rdata;
  assign avs_waitrequest = s_r.waitrequest;
  assign irq_req = s_r.req;
  assign irq_vector = s_r.vector;
  assign irq_level = s_r.level;

endmodule : vectored_irq_unit
`default_nettype wire

// ---- test/core_model.sv ----
`timescale 1ns/10ps
`default_nettype none
module core_model (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // Unit side
  input wire logic irq_req,
  output logic vector_ack,
  output logic service_return,
  // Bench control
  input wire logic slow,
  input wire logic ret_req
);
  logic wait_r;
  // A slow core lets the request stand one cycle longer before taking it
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      wait_r <= 1'b0;
      vector_ack <= 1'b0;
      service_return <= 1'b0;
    end else begin
      wait_r <= irq_req && slow && !wait_r && !vector_ack;
      vector_ack <= irq_req && !vector_ack && (!slow || wait_r);
      service_return <= ret_req;
    end
  end
endmodule : core_model
`default_nettype wire

// ---- test/irq_unit_sva.sv ----
`timescale 1ns/10ps
`default_nettype none
`include "irq_unit_defines.svh"
module irq_unit_sva (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // Bus handshake
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic avs_waitrequest,
  // Core side
  input wire logic vector_ack,
  input wire logic service_return,
  input wire logic irq_req,
  input wire logic [7:0] irq_vector,
  input wire logic [2:0] irq_level
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  logic [4:0] svc_r, svc_nxt, top;
  logic wr_seen_r, take;
  assign take = vector_ack && irq_req;
  ////////////////////////////////////////
  // Mirror of the in-service levels; a return pops the highest one
  always_comb begin
    top = 5'h00;
    for (int i = 0; i < 5; i++) begin
      if (svc_r[i]) top = 5'h01 << i;
    end
    svc_nxt = svc_r;
    if (take) svc_nxt[irq_level] = 1'b1;
    else if (service_return) svc_nxt = svc_r & ~top;
  end
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      svc_r <= 5'h00;
      wr_seen_r <= 1'b0;
    end else begin
      svc_r <= svc_nxt;
      wr_seen_r <= wr_seen_r || (avs_write && !avs_waitrequest);
    end
  end
  ////////////////////////////////////////
  a_preempt_strict: assert property (take |-> (svc_r >> irq_level) == 5'h00)
    else $error("take at a level not above the running one");
  a_ack_drops_req: assert property (take |=> !irq_req)
    else $error("request stands after it was taken");
  a_pf_level: assert property (irq_req && irq_vector == `VEC_PF |-> irq_level == `LVL_PF)
    else $error("power-fail offered below top level");
  a_other_level: assert property (irq_req && irq_vector != `VEC_PF |-> irq_level < 3'h4)
    else $error("ordinary source offered at top level");
  a_vector_legal: assert property (irq_req |-> irq_vector inside {`VEC_PF, `VEC_EXT0,
    `VEC_TF0, `VEC_EXT1, `VEC_TF1, `VEC_SER0, `VEC_TMR2, `VEC_SER1, `VEC_EXT2,
    `VEC_EXT3, `VEC_EXT4, `VEC_EXT5, `VEC_WDOG})
    else $error("unknown vector offered");
  a_quiet_unset: assert property (!wr_seen_r |-> !irq_req)
    else $error("request before any enable was written");
  a_reset_idle: assert property ($rose(rst_n) |-> !irq_req && irq_level == 3'h0)
    else $error("outputs not idle after reset");
  a_bus_one_wait: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("bus answer late");
endmodule : irq_unit_sva
bind vectored_irq_unit irq_unit_sva irq_unit_sva_inst (.core_clk, .rst_n, .avs_read,
  .avs_write, .avs_waitrequest, .vector_ack, .service_return, .irq_req, .irq_vector,
  .irq_level);
`default_nettype wire

// ---- test/testbench.sv ----
`timescale 1ns/10ps
`default_nettype none
`include "irq_unit_defines.svh"
module testbench;
  logic core_clk, rst_n, avs_read, avs_write, avs_waitrequest, powerfail_warn;
  logic [5:0] avs_address, ext_irq_pin_n;
  logic [31:0] avs_writedata, avs_readdata, q;
  logic [8:0] pulse;
  logic vector_ack, service_return, irq_req, slow, ret_req;
  logic [7:0] irq_vector;
  logic [2:0] irq_level;
  logic [7:0] vt [13];
  logic [10:0] expq [$];
  int n_mismatch, check_count, n_take, k;
  vectored_irq_unit vectored_irq_unit_inst (.core_clk, .rst_n, .avs_address, .avs_read,
    .avs_write, .avs_writedata, .avs_byteenable(4'hf), .avs_readdata, .avs_waitrequest,
    .ext_irq_pin_n, .powerfail_warn, .timer0_ovf_pulse(pulse[0]), .timer1_ovf_pulse(pulse[1]),
    .timer2_ovf_pulse(pulse[2]), .timer2_ext_pulse(pulse[3]), .serial0_rx_pulse(pulse[4]),
    .serial0_tx_pulse(pulse[5]), .serial1_rx_pulse(pulse[6]), .serial1_tx_pulse(pulse[7]),
    .wdog_timeout_pulse(pulse[8]), .vector_ack, .service_return, .irq_req, .irq_vector,
    .irq_level);
  core_model core_model_inst (.core_clk, .rst_n, .irq_req, .vector_ack, .service_return,
    .slow, .ret_req);
  ////////////////////////////////////////
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic summarize();
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : summarize
  task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d);
    int n;
    @(posedge core_clk);
    avs_read <= !w;
    avs_write <= w;
    avs_address <= a;
    avs_writedata <= d;
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    if (n >= 50) check(1, 0);
    if (n >= 50) summarize();
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask : bus
  task automatic rd_chk(input logic [5:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    check(q, exp);
  endtask : rd_chk
  task automatic drive(input int s, input int r, input logic v);
    if (s == 0) powerfail_warn <= v;
    else if (s == 1 || s == 3) ext_irq_pin_n[s/2] <= !v;
    else if (s >= 8 && s <= 11) ext_irq_pin_n[s-6] <= !v;
    else if (s == 2 || s == 4) pulse[s/2-1] <= v;
    else if (s == 12) pulse[8] <= v;
    else pulse[s == 6 ? 2 + r : s == 5 ? 4 + r : 6 + r] <= v;
  endtask : drive
  task automatic fire(input int s);
    int r;
    r = $urandom % 2;
    @(posedge core_clk);
    drive(s, r, 1'b1);
    @(posedge core_clk);
    drive(s, r, 1'b0);
  endtask : fire
  task automatic take(input logic [7:0] v, input logic [2:0] l, input int s);
    int n;
    expq.push_back({v, l});
    if (s >= 0) fire(s);
    k++;
    for (n = 0; n_take < k && n < 300; n++) @(posedge core_clk);
    if (n >= 300) check(1, 0);
    if (n >= 300) summarize();
  endtask : take
  task automatic ret();
    @(posedge core_clk);
    ret_req <= 1'b1;
    @(posedge core_clk);
    ret_req <= 1'b0;
  endtask : ret
  task automatic idle_chk();
    repeat (8) @(posedge core_clk);
    check(irq_req, 0);
  endtask : idle_chk
  ////////////////////////////////////////
  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end
  // Every taken vector is compared with the oldest note
  always @(posedge core_clk) begin
    if (rst_n === 1'b1 && vector_ack === 1'b1 && irq_req === 1'b1) begin
      check({irq_vector, irq_level}, expq.pop_front());
      n_take++;
    end
  end
  initial begin
    rst_n = 1'b0;
    {avs_read, avs_write, powerfail_warn, slow, ret_req} = 5'h00;
    avs_address = 6'h00;
    avs_writedata = 32'h0;
    ext_irq_pin_n = 6'h3f;
    pulse = 9'h000;
    vt = '{`VEC_PF, `VEC_EXT0, `VEC_TF0, `VEC_EXT1, `VEC_TF1, `VEC_SER0, `VEC_TMR2,
      `VEC_SER1, `VEC_EXT2, `VEC_EXT3, `VEC_EXT4, `VEC_EXT5, `VEC_WDOG};
    repeat (20) @(posedge core_clk);
    rst_n <= 1'b1;
    void'($urandom(88));
    for (int a = 0; a <= 40; a += 4) if (a != 36) rd_chk(6'(a), 32'h0);
    rd_chk(`OFS_STATUS, {24'h000000, `VEC_PF});
    bus(1, `OFS_IE, 32'h7f);
    fire(2);
    idle_chk();
    rd_chk(`OFS_FLAG_CLR, 32'h2);
    bus(1, `OFS_CTRL, 32'h1);
    take(`VEC_PF, `LVL_PF, 0);
    bus(1, `OFS_FLAG_CLR, 32'hffff);
    ret();
    bus(1, `OFS_CTRL, 32'h0);
    fire(0);
    idle_chk();
    rd_chk(`OFS_FLAG_CLR, 32'h8000);
    bus(1, `OFS_IE, 32'h80);
    bus(1, `OFS_FLAG_CLR, 32'hffff);
    fire(4);
    idle_chk();
    bus(1, `OFS_FLAG_CLR, 32'hffff);
    bus(1, `OFS_IE, 32'hff);
    bus(1, `OFS_EIE, 32'h1f);
    bus(1, `OFS_CTRL, 32'h1);
    for (int s = 0; s < 13; s++) begin
      slow <= 1'($urandom % 2);
      take(vt[s], s == 0 ? `LVL_PF : 3'h0, s);
      if (s >= 1 && s <= 4) rd_chk(`OFS_FLAG_CLR, 32'h0);
      bus(1, `OFS_FLAG_CLR, 32'hffff);
      ret();
    end
    bus(1, `OFS_PLOW, 32'h02);
    bus(1, `OFS_PMID, 32'h40);
    bus(1, `OFS_FLAG_SET, 32'h010e);
    take(`VEC_SER1, 3'h2, -1);
    bus(1, `OFS_FLAG_CLR, 32'h0100);
    idle_chk();
    ret();
    take(`VEC_TF0, 3'h1, -1);
    ret();
    take(`VEC_EXT1, 3'h0, -1);
    idle_chk();
    take(`VEC_PF, `LVL_PF, 0);
    bus(1, `OFS_FLAG_CLR, 32'h8000);
    ret();
    ret();
    take(`VEC_TF1, 3'h0, -1);
    ret();
    // Watchdog at level 3 must beat timer 0 at level 1 despite its natural order
    bus(1, `OFS_EPLOW, 32'h10);
    bus(1, `OFS_EPMID, 32'h10);
    bus(1, `OFS_FLAG_SET, 32'h4002);
    take(`VEC_WDOG, 3'h3, -1);
    bus(1, `OFS_FLAG_CLR, 32'h4000);
    ret();
    take(`VEC_TF0, 3'h1, -1);
    ret();
    bus(1, `OFS_IE, 32'h0);
    bus(1, `OFS_CTRL, 32'h2);
    ext_irq_pin_n[0] <= 1'b0;
    repeat (6) @(posedge core_clk);
    rd_chk(`OFS_FLAG_CLR, 32'h1);
    ext_irq_pin_n[0] <= 1'b1;
    repeat (6) @(posedge core_clk);
    rd_chk(`OFS_FLAG_CLR, 32'h0);
    summarize();
  end
endmodule : testbench
`default_nettype wire
